/* File: rtl/pmirq_regs.sv */
// Interrupt enable/status and metric selector registers of the
// bus performance monitor. Assumes a synchronous single-cycle
// register port, one clock, and overflow pulses from the counters.
module pmirq_regs
  import pmirq_pkg::*;
#(
  parameter int NUM_CNT = PMIRQ_NCNT_MAX
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  // Mode
  input wire pmirq_mode_e mode,
  input wire logic log_on,
  // Overflow events, one-cycle pulses
  input wire logic ovf_gclk,
  input wire logic ovf_samp,
  input wire logic ovf_fifo,
  input wire logic [PMIRQ_NCNT_MAX-1:0] ovf_cnt,
  // Interrupt and selections
  output logic irq,
  output logic [PMIRQ_NSEL*PMIRQ_KIND_W-1:0] sel_kind,
  output logic [PMIRQ_NSEL*PMIRQ_SLOT_W-1:0] sel_slot,
  output logic [PMIRQ_NSEL-1:0] sel_valid,
  output logic [PMIRQ_NSEL*2-1:0] sel_class
);
  // ==========================================================
  // State
  typedef struct packed {
    logic gate;
    logic [PMIRQ_NSRC-1:0] en;
    logic [PMIRQ_NSRC-1:0] stat;
    logic [31:0] sel_low;
    logic [31:0] sel_mid;
    logic [31:0] rdata;
    logic ack;
    logic irq;
    logic [PMIRQ_NSEL*PMIRQ_KIND_W-1:0] kind;
    logic [PMIRQ_NSEL*PMIRQ_SLOT_W-1:0] slot;
    logic [PMIRQ_NSEL-1:0] valid;
    logic [PMIRQ_NSEL*2-1:0] cls;
  } pmirq_state_s;

  pmirq_state_s state_r;
  pmirq_state_s state_nxt;

  // Bits of selector fields whose counter is actually built
  function automatic logic [31:0] sel_mask(input int base);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < PMIRQ_SEL_PER_REG; i++) begin
      if (base + i < NUM_CNT) begin
        m[i*PMIRQ_SEL_BYTE +: PMIRQ_SEL_BYTE] = 8'hff;
      end
    end
    return m;
  endfunction

  localparam logic [31:0] MASK_LOW = sel_mask(0);
  localparam logic [31:0] MASK_MID = sel_mask(PMIRQ_SEL_PER_REG);

  // Source implementation mask: unbuilt counters never set
  function automatic logic [PMIRQ_NSRC-1:0] src_mask();
    logic [PMIRQ_NSRC-1:0] m;
    m = '0;
    m[PMIRQ_BIT_CNT0-1:0] = '1;
    for (int i = 0; i < PMIRQ_NCNT_MAX; i++) begin
      if (i < NUM_CNT) begin
        m[PMIRQ_BIT_CNT0+i] = 1'b1;
      end
    end
    return m;
  endfunction

  localparam logic [PMIRQ_NSRC-1:0] MASK_SRC = src_mask();

  // ==========================================================
  // Event qualification by mode
  logic adv;
  logic [PMIRQ_NSRC-1:0] evt;
  logic [PMIRQ_NSRC-1:0] w1c;
  logic hit_gate;
  logic hit_en;
  logic hit_stat;
  logic hit_low;
  logic hit_mid;

  always_comb begin
    adv = (mode == PMIRQ_MODE_ADV);
    evt = '0;
    evt[PMIRQ_BIT_GCLK] = ovf_gclk & adv;
    evt[PMIRQ_BIT_SAMP] = ovf_samp &
        (adv | (mode == PMIRQ_MODE_PROF));
    evt[PMIRQ_BIT_FIFO] = ovf_fifo &
        ((mode == PMIRQ_MODE_TRACE) | (adv & log_on));
    evt[PMIRQ_NSRC-1:PMIRQ_BIT_CNT0] = ovf_cnt & {PMIRQ_NCNT_MAX{adv}};
    evt = evt & MASK_SRC;
  end

  always_comb begin
    hit_gate = reg_addr == PMIRQ_OFS_GATE;
    hit_en = reg_addr == PMIRQ_OFS_EN;
    hit_stat = reg_addr == PMIRQ_OFS_STAT;
    hit_low = reg_addr == PMIRQ_OFS_SEL_LOW;
    hit_mid = reg_addr == PMIRQ_OFS_SEL_MID;
    w1c = (reg_wr && hit_stat) ? reg_wdata[PMIRQ_NSRC-1:0] : '0;
  end

  // ==========================================================
  // Selector decode, one per selector byte, PMIRQ_NSEL in all
  pmirq_cls_e cls_w [PMIRQ_NSEL];
  logic [PMIRQ_KIND_W-1:0] kind_w [PMIRQ_NSEL];
  logic [PMIRQ_SLOT_W-1:0] slot_w [PMIRQ_NSEL];
  logic [63:0] sel_all;

  assign sel_all = {state_r.sel_mid, state_r.sel_low};

  genvar g;
  generate
    for (g = 0; g < PMIRQ_NSEL; g++) begin : g_dec
      pmirq_decode u_dec (
        .sel_byte(sel_all[g*PMIRQ_SEL_BYTE +: PMIRQ_SEL_BYTE]),
        .active(adv && (g < NUM_CNT)),
        .cls(cls_w[g]),
        .kind(kind_w[g]),
        .slot(slot_w[g]),
        .ext_onehot()
      );
    end
  endgenerate

  // ==========================================================
  // Next state
  always_comb begin
    state_nxt = state_r;
    state_nxt.ack = reg_wr | reg_rd;
    // Set wins over a clear landing in the same cycle
    state_nxt.stat = (state_r.stat & ~w1c) | evt;
    if (reg_wr && hit_gate) begin
      state_nxt.gate = reg_wdata[0];
    end
    if (reg_wr && hit_en) begin
      state_nxt.en = reg_wdata[PMIRQ_NSRC-1:0] & MASK_SRC;
    end
    if (reg_wr && hit_low) begin
      state_nxt.sel_low = reg_wdata & MASK_LOW;
    end
    if (reg_wr && hit_mid) begin
      state_nxt.sel_mid = reg_wdata & MASK_MID;
    end
    state_nxt.rdata = '0;
    if (reg_rd) begin
      if (hit_gate) begin
        state_nxt.rdata = {31'h0000_0000, state_r.gate};
      end else if (hit_en) begin
        state_nxt.rdata = {19'h0_0000, state_r.en};
      end else if (hit_stat) begin
        state_nxt.rdata = {19'h0_0000, state_r.stat};
      end else if (hit_low) begin
        state_nxt.rdata = state_r.sel_low;
      end else if (hit_mid) begin
        state_nxt.rdata = state_r.sel_mid;
      end
    end
    // Output from the registered state, so it lags status by a cycle
    state_nxt.irq = state_r.gate &
        (|(state_r.stat & state_r.en));
    for (int i = 0; i < PMIRQ_NSEL; i++) begin
      state_nxt.kind[i*PMIRQ_KIND_W +: PMIRQ_KIND_W] = kind_w[i];
      state_nxt.slot[i*PMIRQ_SLOT_W +: PMIRQ_SLOT_W] = slot_w[i];
      state_nxt.valid[i] = cls_w[i] != PMIRQ_CLS_NONE;
      state_nxt.cls[i*2 +: 2] = cls_w[i];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign reg_rdata = state_r.rdata;
  assign reg_ack = state_r.ack;
  assign irq = state_r.irq;
  assign sel_kind = state_r.kind;
  assign sel_slot = state_r.slot;
  assign sel_valid = state_r.valid;
  assign sel_class = state_r.cls;

  // ==========================================================
  // Checks
  a_capture_masked: assert property (@(posedge clk) disable iff (rst)
    evt[PMIRQ_BIT_SAMP] |=> state_r.stat[PMIRQ_BIT_SAMP])
    else $error("sample overflow not captured");
  a_irq_follows: assert property (@(posedge clk) disable iff (rst)
    (state_r.gate && |(state_r.stat & state_r.en)) |=> irq)
    else $error("irq not raised for enabled pending source");
  a_irq_masked: assert property (@(posedge clk) disable iff (rst)
    (~|(state_r.stat & state_r.en)) |=> !irq)
    else $error("irq raised with no enabled pending source");
  a_gate_off: assert property (@(posedge clk) disable iff (rst)
    !state_r.gate |=> !irq)
    else $error("irq raised while gate closed");
  a_w1c_clear: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && hit_stat && reg_wdata[0] && !evt[0])
      |=> !state_r.stat[0])
    else $error("status bit not cleared by write of one");
  a_w0_keep: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && hit_stat && !reg_wdata[1] && state_r.stat[1])
      |=> state_r.stat[1])
    else $error("status bit lost on write of zero");
  a_gclk_adv: assert property (@(posedge clk) disable iff (rst)
    (mode != PMIRQ_MODE_ADV && !state_r.stat[PMIRQ_BIT_GCLK])
      |=> !state_r.stat[PMIRQ_BIT_GCLK])
    else $error("clock overflow set outside advanced mode");
  a_fifo_mode: assert property (@(posedge clk) disable iff (rst)
    (mode == PMIRQ_MODE_PROF && !state_r.stat[PMIRQ_BIT_FIFO])
      |=> !state_r.stat[PMIRQ_BIT_FIFO])
    else $error("FIFO overflow set in profile mode");
  a_stat_read: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && hit_stat) |=> (reg_rdata[PMIRQ_NSRC-1:0] ==
      $past(state_r.stat)) && reg_ack)
    else $error("status read mismatch");
  a_sel_adv: assert property (@(posedge clk) disable iff (rst)
    (mode != PMIRQ_MODE_ADV) |=> (sel_valid == '0))
    else $error("selector active outside advanced mode");

  // ==========================================================
  // Mode qualification checks
  a_samp_prof: assert property (@(posedge clk) disable iff (rst)
    (ovf_samp && mode == PMIRQ_MODE_PROF)
      |=> state_r.stat[PMIRQ_BIT_SAMP])
    else $error("interval overflow lost in profile mode");
  a_fifo_trace: assert property (@(posedge clk) disable iff (rst)
    (ovf_fifo && mode == PMIRQ_MODE_TRACE)
      |=> state_r.stat[PMIRQ_BIT_FIFO])
    else $error("FIFO overflow lost in trace mode");
  a_fifo_logged: assert property (@(posedge clk) disable iff (rst)
    (ovf_fifo && adv && log_on) |=> state_r.stat[PMIRQ_BIT_FIFO])
    else $error("FIFO overflow lost with logging on");
  a_fifo_unlogged: assert property (@(posedge clk) disable iff (rst)
    (adv && !log_on && !state_r.stat[PMIRQ_BIT_FIFO])
      |=> !state_r.stat[PMIRQ_BIT_FIFO])
    else $error("FIFO overflow set with logging off");
  a_gclk_capture: assert property (@(posedge clk) disable iff (rst)
    (ovf_gclk && adv) |=> state_r.stat[PMIRQ_BIT_GCLK])
    else $error("clock overflow lost in advanced mode");
  a_cnt_capture: assert property (@(posedge clk) disable iff (rst)
    (ovf_cnt[0] && adv && MASK_SRC[PMIRQ_BIT_CNT0])
      |=> state_r.stat[PMIRQ_BIT_CNT0])
    else $error("counter overflow lost in advanced mode");
  a_cnt_adv: assert property (@(posedge clk) disable iff (rst)
    (!adv && ~|state_r.stat[PMIRQ_NSRC-1:PMIRQ_BIT_CNT0])
      |=> ~|state_r.stat[PMIRQ_NSRC-1:PMIRQ_BIT_CNT0])
    else $error("counter overflow set outside advanced mode");

  // ==========================================================
  // Layout and register port checks
  a_en_write: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && hit_en)
      |=> 32'(state_r.en) == ($past(reg_wdata) & 32'(MASK_SRC)))
    else $error("enable write not stored");
  a_unbuilt_zero: assert property (@(posedge clk) disable iff (rst)
    ((state_r.stat | state_r.en) & ~MASK_SRC) == '0)
    else $error("unbuilt counter bit set");
  a_rsvd_read: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && (hit_en || hit_stat)) |=> (reg_rdata >> PMIRQ_NSRC) == '0)
    else $error("reserved bits read nonzero");
  a_ack_pulse: assert property (@(posedge clk) disable iff (rst)
    (reg_wr || reg_rd) |=> reg_ack)
    else $error("register access not acknowledged");

  // ==========================================================
  // Selector checks
  a_sel_low_wr: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && hit_low) |=> state_r.sel_low == ($past(reg_wdata) & MASK_LOW))
    else $error("low selector write not stored");
  a_sel_mid_wr: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && hit_mid) |=> state_r.sel_mid == ($past(reg_wdata) & MASK_MID))
    else $error("mid selector write not stored");
  a_slot_follow: assert property (@(posedge clk) disable iff (rst)
    !(reg_wr && hit_low) |=> sel_slot[PMIRQ_SLOT_W-1:0] ==
      state_r.sel_low[PMIRQ_SEL_BYTE-1:PMIRQ_KIND_W])
    else $error("slot output does not follow selector");
  a_kind_follow: assert property (@(posedge clk) disable iff (rst)
    !(reg_wr && hit_mid)
      |=> sel_kind[PMIRQ_SEL_PER_REG*PMIRQ_KIND_W +: PMIRQ_KIND_W] ==
        state_r.sel_mid[PMIRQ_KIND_W-1:0])
    else $error("kind output does not follow selector");
  a_bus_class: assert property (@(posedge clk) disable iff (rst)
    (adv && NUM_CNT > 0 &&
      state_r.sel_low[PMIRQ_KIND_W-1:0] <= PMIRQ_KIND_BUS_LAST)
      |=> (sel_class[1:0] == PMIRQ_CLS_BUS) && sel_valid[0])
    else $error("bus metric kind misclassified");
  a_unbuilt_sel: assert property (@(posedge clk) disable iff (rst)
    (sel_valid >> NUM_CNT) == '0)
    else $error("unbuilt counter selection active");
endmodule

/* File: rtl/pmirq_pkg.sv */
// Package for the monitor interrupt and metric selector register bank.
// Assumes a simple synchronous register port on one clock.
package pmirq_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [15:0] PMIRQ_OFS_GATE = 16'h0030;
  localparam logic [15:0] PMIRQ_OFS_EN = 16'h0034;
  localparam logic [15:0] PMIRQ_OFS_STAT = 16'h0038;
  localparam logic [15:0] PMIRQ_OFS_SEL_LOW = 16'h0044;
  localparam logic [15:0] PMIRQ_OFS_SEL_MID = 16'h0048;
  // ==========================================================
  // Interrupt bit layout
  localparam int PMIRQ_NSRC = 13;
  localparam int PMIRQ_BIT_GCLK = 0;
  localparam int PMIRQ_BIT_SAMP = 1;
  localparam int PMIRQ_BIT_FIFO = 2;
  localparam int PMIRQ_BIT_CNT0 = 3;
  localparam int PMIRQ_NCNT_MAX = 10;
  localparam logic [31:0] PMIRQ_RST_VAL = 32'h0000_0000;
  // ==========================================================
  // Selector layout: one byte per counter
  localparam int PMIRQ_SEL_PER_REG = 4;
  localparam int PMIRQ_SEL_BYTE = 8;
  localparam int PMIRQ_KIND_W = 5;
  localparam int PMIRQ_SLOT_W = 3;
  localparam int PMIRQ_NSEL = 8;
  localparam logic [4:0] PMIRQ_KIND_BUS_LAST = 5'h0f;
  localparam logic [4:0] PMIRQ_KIND_STRM_FIRST = 5'h10;
  localparam logic [4:0] PMIRQ_KIND_STRM_LAST = 5'h16;
  localparam logic [4:0] PMIRQ_KIND_EXT = 5'h1e;
  // ==========================================================
  // Operating modes and metric classes
  typedef enum logic [1:0] {
    PMIRQ_MODE_ADV,
    PMIRQ_MODE_PROF,
    PMIRQ_MODE_TRACE
  } pmirq_mode_e;
  typedef enum logic [1:0] {
    PMIRQ_CLS_BUS,
    PMIRQ_CLS_STRM,
    PMIRQ_CLS_EXT,
    PMIRQ_CLS_NONE
  } pmirq_cls_e;
endpackage

/* File: rtl/pmirq_decode.sv */
// Decoder for one counter's selector byte: metric class and slot.
// Takes the advanced-mode qualifier on active and gates the class with it.
module pmirq_decode
  import pmirq_pkg::*;
(
  // Selector byte and qualifier
  input wire logic [7:0] sel_byte,
  input wire logic active,
  // Decoded selection
  output pmirq_cls_e cls,
  output logic [PMIRQ_KIND_W-1:0] kind,
  output logic [PMIRQ_SLOT_W-1:0] slot,
  output logic [PMIRQ_NCNT_MAX-3:0] ext_onehot
);
  // ==========================================================
  // Classification
  function automatic pmirq_cls_e classify(input logic [4:0] k);
    if (k <= PMIRQ_KIND_BUS_LAST) begin
      return PMIRQ_CLS_BUS;
    end else if (k >= PMIRQ_KIND_STRM_FIRST &&
                 k <= PMIRQ_KIND_STRM_LAST) begin
      return PMIRQ_CLS_STRM;
    end else if (k == PMIRQ_KIND_EXT) begin
      return PMIRQ_CLS_EXT;
    end
    return PMIRQ_CLS_NONE;
  endfunction

  always_comb begin
    kind = sel_byte[PMIRQ_KIND_W-1:0];
    slot = sel_byte[PMIRQ_SEL_BYTE-1:PMIRQ_KIND_W];
    cls = active ? classify(kind) : PMIRQ_CLS_NONE;
    ext_onehot = '0;
    if (cls == PMIRQ_CLS_EXT) begin
      ext_onehot[slot] = 1'b1;
    end
  end
endmodule

/* File: dv/pmirq_evt_src.sv */
// Model of the counter side: turns a request mask into overflow pulses.
// Assumes requests arrive by non-blocking assignment at rising edges.
module pmirq_evt_src
  import pmirq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request from the bench
  input wire logic go,
  input wire logic [PMIRQ_NSRC-1:0] mask,
  // Overflow pulses
  output logic ovf_gclk,
  output logic ovf_samp,
  output logic ovf_fifo,
  output logic [PMIRQ_NCNT_MAX-1:0] ovf_cnt
);
  logic [PMIRQ_NSRC-1:0] pulse_r;
  // One cycle per request: a counter wraps at most once per event
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_r <= '0;
    end else begin
      pulse_r <= go ? mask : '0;
    end
  end
  assign ovf_gclk = pulse_r[PMIRQ_BIT_GCLK];
  assign ovf_samp = pulse_r[PMIRQ_BIT_SAMP];
  assign ovf_fifo = pulse_r[PMIRQ_BIT_FIFO];
  assign ovf_cnt = pulse_r[PMIRQ_NSRC-1:PMIRQ_BIT_CNT0];
endmodule

/* File: dv/perf_monitor_irq_and_metric_select_tb.sv */
// Self-checking bench for the interrupt and selector register bank.
// Assumes the single-cycle register port and the event model beside it.
module perf_monitor_irq_and_metric_select_tb
  import pmirq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals; seven counters built so counter 7 is reserved
  localparam int NC = 7;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata;
  logic reg_ack;
  pmirq_mode_e mode = PMIRQ_MODE_ADV;
  logic log_on = 1'b1;
  logic go = 1'b0;
  logic [12:0] mask = 13'h0000;
  logic ovf_gclk, ovf_samp, ovf_fifo, irq;
  logic [9:0] ovf_cnt;
  logic [39:0] sel_kind;
  logic [23:0] sel_slot;
  logic [7:0] sel_valid;
  logic [15:0] sel_class;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  pmirq_regs #(.NUM_CNT(NC)) dut_u (.clk(clk), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .mode(mode), .log_on(log_on), .ovf_gclk(ovf_gclk),
    .ovf_samp(ovf_samp), .ovf_fifo(ovf_fifo), .ovf_cnt(ovf_cnt),
    .irq(irq), .sel_kind(sel_kind), .sel_slot(sel_slot),
    .sel_valid(sel_valid), .sel_class(sel_class));
  pmirq_evt_src src_u (.clk(clk), .rst(rst), .go(go), .mask(mask),
    .ovf_gclk(ovf_gclk), .ovf_samp(ovf_samp), .ovf_fifo(ovf_fifo),
    .ovf_cnt(ovf_cnt));
  initial begin
    forever #2 clk = ~clk;
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({31'h0, reg_ack}, 32'h1, "read ack");
    chk(reg_rdata, e, "read data");
  endtask
  task automatic fire(input logic [12:0] m);
    @(posedge clk);
    go <= 1'b1;
    mask <= m;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic irq_chk(input logic e);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, irq}, {31'h0, e}, "irq level");
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd_chk(PMIRQ_OFS_EN, 32'h0);
    rd_chk(PMIRQ_OFS_STAT, 32'h0);
    rd_chk(PMIRQ_OFS_GATE, 32'h0);
    rd_chk(16'h003c, 32'h0);
  endtask
  task automatic t_enable();
    wr(PMIRQ_OFS_EN, 32'hffff_ffff);
    rd_chk(PMIRQ_OFS_EN, 32'h0000_03ff);
    wr(PMIRQ_OFS_EN, 32'h0);
  endtask
  // Masked capture, then gate, enable and clear interplay
  task automatic t_irq();
    wr(PMIRQ_OFS_GATE, 32'h1);
    fire(13'h1fff);
    irq_chk(1'b0);
    rd_chk(PMIRQ_OFS_STAT, 32'h0000_03ff);
    wr(PMIRQ_OFS_EN, 32'h2);
    irq_chk(1'b1);
    wr(PMIRQ_OFS_GATE, 32'h0);
    irq_chk(1'b0);
    wr(PMIRQ_OFS_GATE, 32'h1);
    wr(PMIRQ_OFS_STAT, 32'h0);
    irq_chk(1'b1);
    wr(PMIRQ_OFS_STAT, 32'h2);
    irq_chk(1'b0);
    rd_chk(PMIRQ_OFS_STAT, 32'h0000_03fd);
  endtask
  task automatic t_modes();
    pmirq_mode_e m[3] = '{PMIRQ_MODE_PROF, PMIRQ_MODE_TRACE,
      PMIRQ_MODE_ADV};
    logic [31:0] e[3] = '{32'h2, 32'h4, 32'h3fb};
    for (int i = 0; i < 3; i++) begin
      wr(PMIRQ_OFS_STAT, 32'h1fff);
      @(posedge clk);
      mode <= m[i];
      log_on <= 1'b0;
      fire(13'h1fff);
      rd_chk(PMIRQ_OFS_STAT, e[i]);
    end
  endtask
  // Bus, stream, external and unknown kinds; counter 7 unbuilt
  task automatic t_select();
    logic [63:0] b = 64'hff9f_770f_36be_50e0;
    logic [15:0] cl = 16'hfc64;
    wr(PMIRQ_OFS_SEL_LOW, b[31:0]);
    wr(PMIRQ_OFS_SEL_MID, b[63:32]);
    rd_chk(PMIRQ_OFS_SEL_LOW, b[31:0]);
    rd_chk(PMIRQ_OFS_SEL_MID, 32'h009f_770f);
    repeat (2) @(posedge clk);
    #1;
    chk({24'h0, sel_valid}, 32'h1f, "valid in advanced");
    for (int i = 0; i < NC; i++) begin
      chk({27'h0, sel_kind[5*i+:5]}, {27'h0, b[8*i+:5]}, "kind");
      chk({29'h0, sel_slot[3*i+:3]}, {29'h0, b[8*i+5+:3]}, "slot");
      chk({30'h0, sel_class[2*i+:2]}, {30'h0, cl[2*i+:2]}, "class");
    end
    chk({27'h0, sel_kind[5*NC+:5]}, 32'h0, "unbuilt kind");
    chk({30'h0, sel_class[2*NC+:2]}, 32'h3, "unbuilt class");
    @(posedge clk);
    mode <= PMIRQ_MODE_PROF;
    repeat (3) @(posedge clk);
    #1;
    chk({24'h0, sel_valid}, 32'h0, "valid outside advanced");
  endtask
  // ==========================================================
  // Run control
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Ceiling well above the hundred or so cycles the scenarios need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      $display("mismatch %0t run did not finish", $time);
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_enable();
    t_irq();
    t_modes();
    t_select();
    complete_run();
  end
endmodule
